// file: logic/cfh_regs.sv
module cfh_regs
#(
    parameter int BASE_CYC = cfh_pkg::CFH_TICK_BASE_CYC,
    parameter int SAMPLES  = cfh_pkg::CFH_SAMPLES
)
(
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]      reg_rdata,
    input  wire logic       jack_raw,
    input  wire logic       stereo_raw,
    input  wire logic       cell_raw,
    input  wire logic       button_raw,
    output logic [1:0]      hpf_left_mode,
    output logic [1:0]      hpf_right_mode,
    output logic            fx_left_en,
    output logic            deemp_left_en,
    output logic            fx_right_en,
    output logic            deemp_right_en,
    output logic            detect_run,
    output logic            out_ac_coupled,
    output logic            out_full_diff,
    output logic            out_pseudo_diff,
    output logic            headset_present,
    output logic            button_event
);
    import cfh_pkg::*;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic       rst_s1_r;       // First reset stage
    logic       rst_n;          // Released reset

    // Two-stage reset release
    // Assertion is immediate, release waits two edges
    always_ff @(posedge sys_clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rst_s1_r <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n    <= rst_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [3:0] pin_s1_r;       // First stage, read only by second
    logic [3:0] pin_s2_r;       // Synchronised pins

    // Two flip-flops per detection pin
    // Pins read as absent until reset ends
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_s1_r <= 4'h0;
            pin_s2_r <= 4'h0;
        end
        else
        begin
            pin_s1_r <= {button_raw, cell_raw, stereo_raw, jack_raw};
            pin_s2_r <= pin_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0] filter_r;       // Filter control
    logic [7:0] det_a_r;        // Writable part of detection A
    logic [7:0] det_b_r;        // Writable part of detection B
    logic       btn_flag_r;     // Sticky button press flag
    logic       wr_filter;      // Write strobe decodes
    logic       wr_det_a;
    logic       wr_det_b;

    // One write strobe per mapped register
    assign wr_filter = reg_wr && (reg_addr == CFH_ADDR_FILTER);
    assign wr_det_a  = reg_wr && (reg_addr == CFH_ADDR_DET_A);
    assign wr_det_b  = reg_wr && (reg_addr == CFH_ADDR_DET_B);

    // Filter register, all bits writable
    // Every code is legal, no masking
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            filter_r <= CFH_RST_FILTER;
        else if (wr_filter)
            filter_r <= reg_wdata;
    end

    // Detection A, result bits masked off
    // Result field is computed live, never stored
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            det_a_r <= CFH_RST_DET_A;   // Detection off at reset
        else if (wr_det_a)
            det_a_r <= reg_wdata & CFH_WMASK_DET_A;   // Type field ignored
    end

    // Detection B, only configuration bits kept
    // Flags live outside this register
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            det_b_r <= CFH_RST_DET_B;
        else if (wr_det_b)
            det_b_r <= reg_wdata & CFH_WMASK_DET_B;   // Flag bits 5:4 and bits 2:0 dropped
    end

    // ------------------------------------------------------------
    // Sample ticks
    // ------------------------------------------------------------
    logic       base_tick;      // 1 ms tick
    logic [6:0] tick_mask;      // 2^k ms ticks
    logic [2:0] jdb_code;       // Jack debounce code
    logic [1:0] bdb_code;       // Button debounce code
    logic       jack_tick;      // Selected jack sample tick
    logic       btn_tick;       // Selected button sample tick
    logic       run;            // Detection enabled

    cfh_tick_gen #(
        .BASE_CYC  (BASE_CYC)
    ) u_tick (
        .sys_clk   (sys_clk),
        .rst_n     (rst_n),
        .base_tick (base_tick),
        .tick_mask (tick_mask)
    );

    // Detection fields steering the detectors
    assign run      = det_a_r[CFH_F_DET_EN];
    assign jdb_code = det_a_r[CFH_F_JDB_LO +: 3];
    assign bdb_code = det_a_r[CFH_F_BDB_LO +: 2];

    // Tick select: jack 2 ms doubling, button 1 ms doubling
    // Code zero leaves the button tick unused
    always_comb
    begin
        jack_tick = 1'b0;
        btn_tick  = 1'b0;
        // Codes above the largest clamp to 64 ms ticks
        if (jdb_code > CFH_JDB_MAX)
            jack_tick = tick_mask[6];
        else
            jack_tick = tick_mask[3'(jdb_code + 3'(CFH_JDB_SHIFT))];
        if (bdb_code != 2'h0)
            btn_tick = tick_mask[3'(bdb_code - 2'h1)];
    end

    // ------------------------------------------------------------
    // Debouncers
    // ------------------------------------------------------------
    logic       jack_clean;     // Debounced jack
    logic       st_clean;       // Debounced stereo sense
    logic       cell_clean;     // Debounced cellular sense
    logic       btn_clean;      // Debounced button
    logic       btn_prev_r;     // Button level last cycle
    logic       btn_press;      // Debounced press edge

    // Jack, stereo and cell share the jack tick
    cfh_debounce #(.SAMPLES(SAMPLES)) u_db_jack (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (run),
        .bypass  (1'b0),
        .sample  (jack_tick),
        .raw     (pin_s2_r[0]),
        .clean   (jack_clean)
    );

    cfh_debounce #(.SAMPLES(SAMPLES)) u_db_st (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (run),
        .bypass  (1'b0),
        .sample  (jack_tick),
        .raw     (pin_s2_r[1]),
        .clean   (st_clean)
    );

    cfh_debounce #(.SAMPLES(SAMPLES)) u_db_cell (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (run),
        .bypass  (1'b0),
        .sample  (jack_tick),
        .raw     (pin_s2_r[2]),
        .clean   (cell_clean)
    );

    // Code zero means no button debounce
    // Raw synced level passes straight through
    cfh_debounce #(.SAMPLES(SAMPLES)) u_db_btn (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .run     (run),
        .bypass  (bdb_code == 2'h0),
        .sample  (btn_tick),
        .raw     (pin_s2_r[3]),
        .clean   (btn_clean)
    );

    // Press edge detector
    // Low at reset like the idle button, no false press
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            btn_prev_r <= 1'b0;
        else
            btn_prev_r <= btn_clean;
    end

    assign btn_press = btn_clean && !btn_prev_r;

    // ------------------------------------------------------------
    // Status
    // ------------------------------------------------------------
    logic [1:0] type_nxt;       // Headset type result
    logic       rd_det_b;       // Read of detection B

    // Reading detection B clears the press flag
    assign rd_det_b = reg_rd && (reg_addr == CFH_ADDR_DET_B);

    // Type valid only with jack present
    // Stale sense levels hidden without a jack
    always_comb
    begin
        if (jack_clean)
            type_nxt = {cell_clean, st_clean};
        else
            type_nxt = 2'h0;
    end

    // Sticky flag, press wins over read clear
    // A press landing on the clearing read is kept
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            btn_flag_r <= 1'b0;
        else if (btn_press)
            btn_flag_r <= 1'b1;
        else if (rd_det_b)
            btn_flag_r <= 1'b0;   // Read clears
    end

    // ------------------------------------------------------------
    // Read data, registered
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            reg_rdata <= 8'h00;
        // Data held unchanged between reads
        else if (reg_rd)
        begin
            unique case (reg_addr)
                CFH_ADDR_FILTER: reg_rdata <= filter_r;
                CFH_ADDR_DET_A:  reg_rdata <= det_a_r | {1'b0, type_nxt, 5'h00};
                // Sticky flag, live flag, zeros low
                CFH_ADDR_DET_B:  reg_rdata <= det_b_r | {2'h0, btn_flag_r, jack_clean, 4'h0};
                default:         reg_rdata <= 8'h00;   // Unmapped reads zero
            endcase
        end
    end

    // ------------------------------------------------------------
    // Control outputs, registered
    // ------------------------------------------------------------
    // Filter controls, one cycle behind the register
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Filters bypassed at reset
            hpf_left_mode   <= 2'h0;
            hpf_right_mode  <= 2'h0;
            fx_left_en      <= 1'b0;
            deemp_left_en   <= 1'b0;
            fx_right_en     <= 1'b0;
            deemp_right_en  <= 1'b0;
        end
        else
        begin
            // Straight copies of stored fields
            hpf_left_mode   <= filter_r[CFH_F_HPF_L_LO +: 2];
            hpf_right_mode  <= filter_r[CFH_F_HPF_R_LO +: 2];
            fx_left_en      <= filter_r[CFH_F_FX_L];
            deemp_left_en   <= filter_r[CFH_F_DEEMP_L];
            fx_right_en     <= filter_r[CFH_F_FX_R];
            deemp_right_en  <= filter_r[CFH_F_DEEMP_R];
        end
    end

    // Detection controls and status
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // Detection off, capless, no wiring mode
            detect_run      <= 1'b0;
            out_ac_coupled  <= 1'b0;
            out_full_diff   <= 1'b0;
            out_pseudo_diff <= 1'b0;
            headset_present <= 1'b0;
            button_event    <= 1'b0;
        end
        else
        begin
            // Stored bits and debounced state
            detect_run      <= run;
            out_ac_coupled  <= det_b_r[CFH_F_ACCPL];
            out_full_diff   <= det_b_r[CFH_F_FULLDIFF];
            out_pseudo_diff <= det_b_r[CFH_F_PSEUDODIFF];
            headset_present <= jack_clean;
            button_event    <= btn_press;
        end
    end

endmodule : cfh_regs

// file: logic/cfh_pkg.sv
package cfh_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] CFH_ADDR_FILTER = 8'h0C;   // codec_filter_control
    localparam logic [7:0] CFH_ADDR_DET_A  = 8'h0D;   // headset_button_detect_a
    localparam logic [7:0] CFH_ADDR_DET_B  = 8'h0E;   // headset_button_detect_b

    // Reset values
    localparam logic [7:0] CFH_RST_FILTER  = 8'h00;
    localparam logic [7:0] CFH_RST_DET_A   = 8'h00;
    localparam logic [7:0] CFH_RST_DET_B   = 8'h00;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CFH_F_HPF_L_LO   = 6;   // Left highpass, bits 7:6
    localparam int CFH_F_HPF_R_LO   = 4;   // Right highpass, bits 5:4
    localparam int CFH_F_FX_L       = 3;
    localparam int CFH_F_DEEMP_L    = 2;
    localparam int CFH_F_FX_R       = 1;
    localparam int CFH_F_DEEMP_R    = 0;
    localparam int CFH_F_DET_EN     = 7;   // Detection register A
    localparam int CFH_F_TYPE_LO    = 5;   // Bits 6:5
    localparam int CFH_F_JDB_LO     = 2;   // Bits 4:2
    localparam int CFH_F_BDB_LO     = 0;   // Bits 1:0
    localparam int CFH_F_ACCPL      = 7;   // Detection register B
    localparam int CFH_F_FULLDIFF   = 6;
    localparam int CFH_F_BTN_FLAG   = 5;
    localparam int CFH_F_HS_FLAG    = 4;
    localparam int CFH_F_PSEUDODIFF = 3;

    // Writable bits masks
    localparam logic [7:0] CFH_WMASK_DET_A = 8'h9F;
    localparam logic [7:0] CFH_WMASK_DET_B = 8'hC8;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CFH_CLK_MHZ       = 200;
    localparam int CFH_TICK_BASE_MS  = 1;   // Shortest sample tick
    localparam int CFH_TICK_BASE_CYC = CFH_TICK_BASE_MS * CFH_CLK_MHZ * 1000;
    localparam int CFH_SAMPLES       = 8;   // Samples per debounce interval
    localparam logic [2:0] CFH_JDB_MAX = 3'h5; // Largest legal jack code
    localparam int CFH_JDB_SHIFT     = 1;   // Jack tick is 2 ms at code 0
    localparam int CFH_PRESC_W       = 7;   // Up to 64 base ticks

endpackage : cfh_pkg

// file: logic/cfh_tick_gen.sv
module cfh_tick_gen
#(
    parameter int BASE_CYC = cfh_pkg::CFH_TICK_BASE_CYC
)
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    output logic            base_tick,
    output logic [6:0]      tick_mask
);
    import cfh_pkg::*;

    // ------------------------------------------------------------
    // Base millisecond tick and power-of-two prescaler
    // ------------------------------------------------------------
    logic [31:0] cyc_r;        // Cycle counter
    logic [6:0]  presc_r;      // Base tick counter

    // Base tick every BASE_CYC cycles
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cyc_r     <= 32'h0;
            base_tick <= 1'b0;
        end
        else if (cyc_r == 32'(BASE_CYC - 1))
        begin
            cyc_r     <= 32'h0;
            base_tick <= 1'b1;
        end
        else
        begin
            cyc_r     <= cyc_r + 32'h1;
            base_tick <= 1'b0;
        end
    end

    // Prescaler advances on each base tick
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            presc_r <= 7'h0;
        else if (base_tick)
            presc_r <= presc_r + 7'h1;
    end

    // Bit k high marks a 2^k ms tick boundary
    always_comb
    begin
        tick_mask[0] = base_tick;
        for (int k = 1; k < 7; k++)
            tick_mask[k] = base_tick && ((presc_r & ~(7'h7F << k)) == 7'h0);   // Low k bits zero
    end

endmodule : cfh_tick_gen

// file: logic/cfh_debounce.sv
module cfh_debounce
#(
    parameter int SAMPLES = cfh_pkg::CFH_SAMPLES
)
(
    input  wire logic       sys_clk,
    input  wire logic       rst_n,
    input  wire logic       run,
    input  wire logic       bypass,
    input  wire logic       sample,
    input  wire logic       raw,
    output logic            clean
);
    import cfh_pkg::*;

    logic [3:0] cnt_r;   // Agreeing samples seen

    // ------------------------------------------------------------
    // Level accepted after SAMPLES agreeing ticks in a row
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 4'h0;
            clean <= 1'b0;
        end
        else if (!run)
        begin
            // Held idle while stopped
            cnt_r <= 4'h0;
            clean <= 1'b0;
        end
        else if (bypass)
        begin
            cnt_r <= 4'h0;
            clean <= raw;
        end
        else if (raw == clean)
            cnt_r <= 4'h0;   // Any agreeing level restarts the window
        else if (sample)
        begin
            if (cnt_r == 4'(SAMPLES - 1))
            begin
                clean <= raw;   // Stable across whole interval
                cnt_r <= 4'h0;
            end
            else
                cnt_r <= cnt_r + 4'h1;
        end
    end

endmodule : cfh_debounce

// file: sim/cfh_regs_properties.sv
// ----------------------------------------
// Port checker for the filter/headset bank
// ----------------------------------------
module cfh_regs_properties
    import cfh_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       reg_wr,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic [1:0] hpf_left_mode,
    input  wire logic [1:0] hpf_right_mode,
    input  wire logic       fx_left_en,
    input  wire logic       deemp_left_en,
    input  wire logic       fx_right_en,
    input  wire logic       deemp_right_en,
    input  wire logic       detect_run,
    input  wire logic       out_ac_coupled,
    input  wire logic       out_full_diff,
    input  wire logic       out_pseudo_diff,
    input  wire logic       headset_present,
    input  wire logic       button_event
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    logic wr_f;   // Write to filter register
    logic wr_a;   // Write to detection register A
    logic wr_b;   // Write to detection register B
    assign wr_f = reg_wr && (reg_addr == CFH_ADDR_FILTER);
    assign wr_a = reg_wr && (reg_addr == CFH_ADDR_DET_A);
    assign wr_b = reg_wr && (reg_addr == CFH_ADDR_DET_B);

    // Outputs follow a write two edges after it is taken
    AST_HPF_L: assert property (wr_f |-> ##2 hpf_left_mode == $past(reg_wdata[7:6], 2))
        else $error("left highpass mode wrong");
    AST_HPF_R: assert property (wr_f ##1 1'b1 |=> hpf_right_mode == $past(reg_wdata[5:4], 2))
        else $error("right highpass mode wrong");
    AST_FX_L: assert property (wr_f |=> ##1 fx_left_en == $past(reg_wdata[3], 2))
        else $error("left effects enable wrong");
    AST_DEEMP_L: assert property (wr_f |-> ##2 deemp_left_en == $past(reg_wdata[2], 2))
        else $error("left de-emphasis enable wrong");
    AST_FX_R: assert property (wr_f |-> ##2 fx_right_en == $past(reg_wdata[1], 2))
        else $error("right effects enable wrong");
    AST_DEEMP_R: assert property (wr_f |-> ##2 deemp_right_en == $past(reg_wdata[0], 2))
        else $error("right de-emphasis enable wrong");
    AST_DET_RUN: assert property (wr_a |-> ##2 detect_run == $past(reg_wdata[7], 2))
        else $error("detection enable wrong");
    AST_AC_CPL: assert property (wr_b |-> ##2 out_ac_coupled == $past(reg_wdata[7], 2))
        else $error("coupling output wrong");
    AST_FULL_DIFF: assert property (wr_b |-> ##2 out_full_diff == $past(reg_wdata[6], 2))
        else $error("fully differential output wrong");
    AST_PSEUDO_DIFF: assert property (wr_b |-> ##2 out_pseudo_diff == $past(reg_wdata[3], 2))
        else $error("pseudo differential output wrong");

    // Main scenarios reached
    cover property (wr_f);
    cover property (button_event);
    cover property ($rose(headset_present));
endmodule : cfh_regs_properties

// file: sim/cfh_host.sv
// ----------------------------------------
// Host model on the register strobes
// ----------------------------------------
module cfh_host (
    input  wire logic       sys_clk,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 100ps;

    // Bus idle at time zero
    initial
    begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // One-cycle write; callers keep codes legal
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;   // Released lines show junk
        reg_wdata <= ~d;
    endtask : wr

    // One-cycle read, data taken after the read edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        @(posedge sys_clk);
        #1;
        d = reg_rdata;
    endtask : rd
endmodule : cfh_host

// file: sim/cfh_regs_bench.sv
module cfh_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;
    import cfh_pkg::*;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic       sys_clk = 1'b0;
    logic       rstn    = 1'b0;
    logic       reg_wr, reg_rd;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic       jack_raw, stereo_raw, cell_raw, button_raw;
    logic [1:0] hpf_left_mode, hpf_right_mode;
    logic       fx_left_en, deemp_left_en, fx_right_en, deemp_right_en;
    logic       detect_run, out_ac_coupled, out_full_diff, out_pseudo_diff;
    logic       headset_present, button_event;
    int         fail_count = 0;
    int         cmp_count  = 0;

    always #2.5 sys_clk = ~sys_clk;   // 200 MHz

    // Short base tick keeps debounce waits small
    cfh_regs #(.BASE_CYC(10), .SAMPLES(8)) i_cfh_regs (.sys_clk, .rstn, .reg_wr, .reg_rd, .reg_addr,
        .reg_wdata, .reg_rdata, .jack_raw, .stereo_raw, .cell_raw, .button_raw, .hpf_left_mode,
        .hpf_right_mode, .fx_left_en, .deemp_left_en, .fx_right_en, .deemp_right_en, .detect_run,
        .out_ac_coupled, .out_full_diff, .out_pseudo_diff, .headset_present, .button_event);
    cfh_host i_cfh_host (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        cmp_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    // Bounded wait for a level: sel 0 headset_present, sel 1 button_event
    task automatic wait_lvl(input logic sel, input logic lvl, input int n, output logic ok);
        ok = 1'b0;
        repeat (n)
        begin
            @(posedge sys_clk);
            #1;
            if ((sel ? button_event : headset_present) === lvl)
            begin
                ok = 1'b1;
                break;
            end
        end
    endtask : wait_lvl

    task automatic pins(input logic [3:0] v);   // jack, stereo, cell, button
        @(posedge sys_clk);
        {jack_raw, stereo_raw, cell_raw, button_raw} <= v;
    endtask : pins

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : finish_test

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [7:0] d;
        i_cfh_host.rd(CFH_ADDR_FILTER, d);
        chk(d, 8'h00, "filter reset");
        i_cfh_host.rd(CFH_ADDR_DET_A, d);
        chk(d, 8'h00, "detect A reset");
        i_cfh_host.rd(CFH_ADDR_DET_B, d);
        chk(d, 8'h00, "detect B reset");
    endtask : t_reset

    // Every highpass code on both sides, each enable both ways
    task automatic t_filter();
        logic [7:0] tbl [4] = '{8'h1A, 8'h65, 8'hB3, 8'hCC};
        logic [7:0] d;
        foreach (tbl[i])
        begin
            i_cfh_host.wr(CFH_ADDR_FILTER, tbl[i]);
            @(posedge sys_clk);
            #1;
            chk({hpf_left_mode, hpf_right_mode, fx_left_en, deemp_left_en, fx_right_en, deemp_right_en},
                tbl[i], "filter outputs");
            i_cfh_host.rd(CFH_ADDR_FILTER, d);
            chk(d, tbl[i], "filter readback");
        end
    endtask : t_filter

    // Type bits ignored; largest jack and button codes kept
    task automatic t_det_a();
        logic [7:0] tbl [3] = '{8'hE0, 8'h94, 8'h83};
        logic [7:0] d;
        foreach (tbl[i])
        begin
            i_cfh_host.wr(CFH_ADDR_DET_A, tbl[i]);
            i_cfh_host.rd(CFH_ADDR_DET_A, d);
            chk(d, tbl[i] & 8'h9F, "detect A readback");
            chk({7'h00, detect_run}, 8'h01, "detect run");
        end
    endtask : t_det_a

    // Wiring modes one at a time, read-only bits ignored
    task automatic t_det_b();
        logic [7:0] tbl [3] = '{8'hB0, 8'h40, 8'h08};
        logic [7:0] d;
        foreach (tbl[i])
        begin
            i_cfh_host.wr(CFH_ADDR_DET_B, tbl[i]);
            i_cfh_host.rd(CFH_ADDR_DET_B, d);
            chk(d, tbl[i] & 8'hC8, "detect B readback");
            chk({out_ac_coupled, out_full_diff, out_pseudo_diff}, {tbl[i][7], tbl[i][6], tbl[i][3]},
                "wiring outputs");
        end
    endtask : t_det_b

    // Jack, every type code, sticky press, live headset flag
    task automatic t_detect();
        logic [7:0] d;
        logic       ok;
        i_cfh_host.wr(CFH_ADDR_DET_A, 8'h81);
        pins(4'b1100);
        repeat (100) @(posedge sys_clk);
        #1;
        chk({7'h00, headset_present}, 8'h00, "early headset");
        wait_lvl(1'b0, 1'b1, 300, ok);
        chk({7'h00, ok}, 8'h01, "headset seen");
        for (int t = 0; t < 4; t++)
        begin
            pins({1'b1, t[0], t[1], 1'b0});
            repeat (200) @(posedge sys_clk);
            i_cfh_host.rd(CFH_ADDR_DET_A, d);
            chk(d, {1'b1, t[1], t[0], 5'h01}, "headset type");
        end
        i_cfh_host.rd(CFH_ADDR_DET_B, d);
        chk(d, 8'h18, "headset flag set");
        pins(4'b1101);
        wait_lvl(1'b1, 1'b1, 200, ok);
        chk({7'h00, ok}, 8'h01, "button event");
        pins(4'b1100);
        i_cfh_host.rd(CFH_ADDR_DET_B, d);
        chk(d, 8'h38, "button flag held");
        i_cfh_host.rd(CFH_ADDR_DET_B, d);
        chk(d, 8'h18, "button flag cleared");
        pins(4'b0000);
        wait_lvl(1'b0, 1'b0, 300, ok);
        chk({7'h00, ok}, 8'h01, "headset gone");
        i_cfh_host.rd(CFH_ADDR_DET_A, d);
        chk(d, 8'h81, "type cleared");
    endtask : t_detect

    // Disabled detection reports and latches nothing
    task automatic t_disable();
        logic [7:0] d;
        logic       ok;
        pins(4'b1100);
        repeat (250) @(posedge sys_clk);
        i_cfh_host.wr(CFH_ADDR_DET_A, 8'h01);
        repeat (4) @(posedge sys_clk);
        #1;
        chk({6'h00, detect_run, headset_present}, 8'h00, "detection off");
        pins(4'b1101);
        wait_lvl(1'b1, 1'b1, 200, ok);
        chk({7'h00, ok}, 8'h00, "no event while off");
        i_cfh_host.rd(CFH_ADDR_DET_B, d);
        chk(d, 8'h08, "no status while off");
        pins(4'b0000);
        i_cfh_host.wr(8'h0F, 8'hFF);
        i_cfh_host.rd(8'h0F, d);
        chk(d, 8'h00, "unmapped read");
        i_cfh_host.rd(CFH_ADDR_FILTER, d);
        chk(d, 8'hCC, "filter untouched");
    endtask : t_disable

    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial
    begin
        {jack_raw, stereo_raw, cell_raw, button_raw} = 4'b0000;
        repeat (8) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (3) @(posedge sys_clk);
        t_reset();
        t_filter();
        t_det_a();
        t_det_b();
        t_detect();
        t_disable();
        finish_test();
    end

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        finish_test();
    end
endmodule : cfh_regs_bench

bind cfh_regs cfh_regs_properties i_cfh_regs_properties (.sys_clk, .rstn, .reg_wr, .reg_addr, .reg_wdata,
    .hpf_left_mode, .hpf_right_mode, .fx_left_en, .deemp_left_en, .fx_right_en, .deemp_right_en,
    .detect_run, .out_ac_coupled, .out_full_diff, .out_pseudo_diff, .headset_present, .button_event);
